// >>> serial_port_pkg.sv
// constants and types shared by the serial configuration port
package serial_port_pkg;

	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int          INSTR_BITS     = 8;
	localparam int          DATA_BITS      = 16;
	localparam int          FRAME_BITS     = INSTR_BITS + DATA_BITS;
	localparam int          DIR_BIT        = 7;
	localparam int          ADDR_MSB_BIT   = 6;
	localparam int          ADDR_WIDTH     = 7;
	localparam int          REG_COUNT      = 128;
	localparam logic [4:0]  CNT_RESET      = 5'h00;
	localparam logic [4:0]  CNT_INSTR_LAST = 5'h07;
	localparam logic [4:0]  CNT_FRAME_LAST = 5'h17;
	localparam logic [15:0] REG_RESET      = 16'h0000;

	// ----------------------------------------
	// interface options register
	// ----------------------------------------
	localparam logic [6:0]  OPTIONS_ADDR     = 7'h02;
	localparam int          FOUR_WIRE_BIT    = 7;
	localparam logic [15:0] OPTIONS_RESET    = 16'h7000;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		st_idle,
		st_instr,
		st_data,
		st_done
	} port_state_type;

	typedef struct packed {
		logic       oe;
		logic       value;
	} pin_drive_type;

	typedef struct packed {
		logic        wr_en;
		logic [6:0]  wr_addr;
		logic [15:0] wr_data;
		logic [6:0]  rd_addr;
	} mem_req_type;

endpackage

// >>> reg_store.sv
// register storage with registered read data except at the options address
`timescale 1ns/100ps
module reg_store
	import serial_port_pkg::*;
(
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        reset_in,
	// access
	input  wire mem_req_type req_in,
	output logic [15:0]      rd_data_out,
	output logic [15:0]      options_out
);

	logic [15:0] mem_r [REG_COUNT];
	logic [15:0] rd_r;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// options word reset separately, the rest need no reset value
	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
			options_out <= OPTIONS_RESET;
		else if (req_in.wr_en && req_in.wr_addr == OPTIONS_ADDR)
			options_out <= req_in.wr_data;
	end

	always_ff @(posedge clock_in)
	begin
		if (req_in.wr_en)
			mem_r[req_in.wr_addr] <= req_in.wr_data;
		rd_r <= mem_r[req_in.rd_addr];
	end

	assign rd_data_out = (req_in.rd_addr == OPTIONS_ADDR) ? options_out : rd_r;

endmodule

// >>> serial_config_port.sv
// serial configuration port, three or four wire, 16-bit registers
`timescale 1ns/100ps

// Notes on behaviour
// - option bit selects three or four wires
// - three wire: data pin is bidirectional
// - four wire: data pin in, output pin out
// - bits sampled on rising serial clock
// - read data changes on falling edge
// - only bits inside enable low count
// - first byte is the instruction byte
// - bit 7 direction, bits 6..0 address
// - one means read, zero means write
// - data phase is exactly two bytes
// - three wire read drives data pin, and both pins after the final fall
// - four wire read drives output pin, and both pins after the final fall
// - after read, drive low until enable rises
module serial_config_port
	import serial_port_pkg::*;
(
	// clock and reset
	input  wire logic  clock_in,
	input  wire logic  reset_in,
	// serial pins
	input  wire logic  serial_clock_in,
	input  wire logic  serial_frame_enable_n_in,
	input  wire logic  serial_data_in,
	output logic       serial_data_out,
	output logic       serial_data_oe_out,
	output logic       serial_read_out,
	output logic       serial_read_oe_out,
	// mode seen by the rest of the chip
	output logic       four_wire_select_out
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// three pins share one two-stage chain; edge taken from stage two
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic       sclk_prev_r;

	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			sync1_r     <= 3'h1;
			sync2_r     <= 3'h1;
			sclk_prev_r <= 1'b0;
		end
		else
		begin
			sync1_r     <= {serial_data_in, serial_clock_in, serial_frame_enable_n_in};
			sync2_r     <= sync1_r;
			sclk_prev_r <= sync2_r[1];
		end
	end

	logic enable_n;
	logic sclk_s;
	logic sdata_s;
	logic rise;
	logic fall;
	assign enable_n = sync2_r[0];
	assign sclk_s   = sync2_r[1];
	assign sdata_s  = sync2_r[2];
	assign rise     = sclk_s & ~sclk_prev_r;
	assign fall     = ~sclk_s & sclk_prev_r;

	// ----------------------------------------
	// frame state
	// ----------------------------------------
	port_state_type state_r;
	port_state_type state_nxt;
	logic [4:0]     cnt_r;
	logic [4:0]     cnt_nxt;
	logic [15:0]    shift_r;
	logic [15:0]    shift_nxt;
	logic           read_r;
	logic           read_nxt;
	logic [6:0]     addr_r;
	logic [6:0]     addr_nxt;
	logic [15:0]    out_sr_r;
	logic [15:0]    out_sr_nxt;
	logic           drive_r;
	logic           drive_nxt;
	logic           bit_r;
	logic           bit_nxt;
	logic           load_r;
	logic           load_nxt;
	logic           tail_r;
	logic           tail_nxt;
	mem_req_type    req;
	logic [15:0]    rd_data;
	logic [15:0]    options;
	logic           four_wire;

	assign four_wire = options[FOUR_WIRE_BIT];

	always_comb
	begin
		state_nxt   = state_r;
		cnt_nxt     = cnt_r;
		shift_nxt   = shift_r;
		read_nxt    = read_r;
		addr_nxt    = addr_r;
		out_sr_nxt  = out_sr_r;
		drive_nxt   = drive_r;
		bit_nxt     = bit_r;
		load_nxt    = 1'b0;
		tail_nxt    = tail_r;
		req.wr_en   = 1'b0;
		req.wr_addr = addr_r;
		req.wr_data = shift_r;
		req.rd_addr = addr_r;
		if (load_r)
			out_sr_nxt = rd_data;
		if (enable_n)
		begin
			// a cut frame never writes; pins released here
			state_nxt = st_idle;
			cnt_nxt   = CNT_RESET;
			drive_nxt = 1'b0;
			bit_nxt   = 1'b0;
			tail_nxt  = 1'b0;
		end
		else
		begin
			case (state_r)
				st_idle:
				begin
					state_nxt = st_instr;
					cnt_nxt   = CNT_RESET;
				end
				st_instr:
				begin
					if (rise)
					begin
						shift_nxt = {shift_r[14:0], sdata_s};
						cnt_nxt   = cnt_r + 5'h01;
						if (cnt_r == CNT_INSTR_LAST)
						begin
							read_nxt  = shift_r[DIR_BIT - 1];
							addr_nxt  = {shift_r[ADDR_MSB_BIT - 1:0], sdata_s};
							req.rd_addr = addr_nxt;
							load_nxt  = 1'b1;
							state_nxt = st_data;
						end
					end
				end
				st_data:
				begin
					if (fall && read_r)
					begin
						// first falling edge after the instruction drives the msb
						drive_nxt  = 1'b1;
						bit_nxt    = out_sr_r[DATA_BITS - 1];
						out_sr_nxt = {out_sr_r[14:0], 1'b0};
					end
					if (rise)
					begin
						shift_nxt = {shift_r[14:0], sdata_s};
						cnt_nxt   = cnt_r + 5'h01;
						if (cnt_r == CNT_FRAME_LAST)
						begin
							req.wr_en   = ~read_r;
							req.wr_data = {shift_r[14:0], sdata_s};
							state_nxt   = st_done;
						end
					end
				end
				default:
				begin
					// extra clocks are ignored; final falling edge drives low
					if (fall && read_r)
					begin
						bit_nxt  = 1'b0;
						tail_nxt = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			state_r  <= st_idle;
			cnt_r    <= CNT_RESET;
			shift_r  <= REG_RESET;
			read_r   <= 1'b0;
			addr_r   <= 7'h00;
			out_sr_r <= REG_RESET;
			drive_r  <= 1'b0;
			bit_r    <= 1'b0;
			load_r   <= 1'b0;
			tail_r   <= 1'b0;
		end
		else
		begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			shift_r  <= shift_nxt;
			read_r   <= read_nxt;
			addr_r   <= addr_nxt;
			out_sr_r <= out_sr_nxt;
			drive_r  <= drive_nxt;
			bit_r    <= bit_nxt;
			load_r   <= load_nxt;
			tail_r   <= tail_nxt;
		end
	end

	// ----------------------------------------
	// storage
	// ----------------------------------------
	reg_store store
	(
		.clock_in    (clock_in),
		.reset_in    (reset_in),
		.req_in      (req),
		.rd_data_out (rd_data),
		.options_out (options)
	);

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	pin_drive_type data_pin_nxt;
	pin_drive_type read_pin_nxt;

	always_comb
	begin
		// four wire: data pin driven only in the tail after the final fall of a read
		data_pin_nxt.oe    = drive_nxt & ~four_wire;
		data_pin_nxt.value = bit_nxt;
		read_pin_nxt.oe    = drive_nxt & four_wire;
		read_pin_nxt.value = bit_nxt;
		// both low only after the final fall, so a zero lsb never drives both pins early
		if (tail_nxt)
		begin
			data_pin_nxt.oe = 1'b1;
			read_pin_nxt.oe = 1'b1;
		end
	end

	always_ff @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			serial_data_out      <= 1'b0;
			serial_data_oe_out   <= 1'b0;
			serial_read_out      <= 1'b0;
			serial_read_oe_out   <= 1'b0;
			four_wire_select_out <= 1'b0;
		end
		else
		begin
			serial_data_out      <= data_pin_nxt.value;
			serial_data_oe_out   <= data_pin_nxt.oe;
			serial_read_out      <= read_pin_nxt.value;
			serial_read_oe_out   <= read_pin_nxt.oe;
			four_wire_select_out <= four_wire;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_release_on_enable;
		@(posedge clock_in) disable iff (reset_in)
		enable_n |=> !drive_r ##1 (!serial_data_oe_out && !serial_read_oe_out);
	endproperty
	a_release_on_enable: assert property (p_release_on_enable) else $error("pins held after enable");

	property p_no_write_outside;
		@(posedge clock_in) disable iff (reset_in)
		enable_n |-> !req.wr_en;
	endproperty
	a_no_write_outside: assert property (p_no_write_outside) else $error("write outside frame");

	property p_write_after_full;
		@(posedge clock_in) disable iff (reset_in)
		req.wr_en |-> (cnt_r == CNT_FRAME_LAST && rise && !read_r);
	endproperty
	a_write_after_full: assert property (p_write_after_full) else $error("early write");

	property p_four_wire_data_in;
		@(posedge clock_in) disable iff (reset_in)
		(four_wire && state_r == st_data) |=> !serial_data_oe_out;
	endproperty
	a_four_wire_data_in: assert property (p_four_wire_data_in) else $error("data pin driven");

	property p_three_wire_quiet;
		@(posedge clock_in) disable iff (reset_in)
		(!four_wire && state_r == st_data) |=> !serial_read_oe_out;
	endproperty
	a_three_wire_quiet: assert property (p_three_wire_quiet) else $error("output pin driven");

	property p_drive_on_fall;
		@(posedge clock_in) disable iff (reset_in)
		(!drive_r && drive_nxt) |-> (fall && read_r);
	endproperty
	a_drive_on_fall: assert property (p_drive_on_fall) else $error("drive not on fall");

	property p_shift_on_rise;
		@(posedge clock_in) disable iff (reset_in)
		(cnt_r != $past(cnt_r) && !enable_n && $past(!enable_n)) |-> $past(rise);
	endproperty
	a_shift_on_rise: assert property (p_shift_on_rise) else $error("bit counted off rise");

	property p_instr_ends_at_eight;
		@(posedge clock_in) disable iff (reset_in)
		(state_r == st_instr && state_nxt == st_data) |-> cnt_r == CNT_INSTR_LAST;
	endproperty
	a_instr_ends_at_eight: assert property (p_instr_ends_at_eight) else $error("bad instr length");

	property p_write_no_drive;
		@(posedge clock_in) disable iff (reset_in)
		(state_r == st_data && !read_r) |-> !drive_r;
	endproperty
	a_write_no_drive: assert property (p_write_no_drive) else $error("driven on write");

	c_write: cover property (@(posedge clock_in) req.wr_en);
	c_read_done: cover property (@(posedge clock_in) state_r == st_done && read_r);
	c_cut_frame: cover property (@(posedge clock_in) state_r == st_data && enable_n);
	c_four_wire_read: cover property (@(posedge clock_in) serial_read_oe_out && four_wire);

endmodule

// >>> serial_host_model.sv
// host-side model that drives the serial configuration pins
`timescale 1ns/100ps
module serial_host_model
(
	// clock
	input  wire logic clock_in,
	// device pins
	input  wire logic data_val_in,
	input  wire logic data_oe_in,
	input  wire logic read_val_in,
	input  wire logic read_oe_in,
	output logic      sclk_out,
	output logic      enable_n_out,
	output logic      data_pin_out
);
	logic host_oe   = 1'b1;
	logic host_bit  = 1'b0;
	logic float_bit = 1'b0;

	// a released pin wanders, so a stale level never passes as data
	always @(negedge clock_in) float_bit <= ~float_bit;
	assign data_pin_out = host_oe ? host_bit : (data_oe_in ? data_val_in : float_bit);
	initial
	begin
		sclk_out     = 1'b0;
		enable_n_out = 1'b1;
	end

	// one frame; low phase 5 cycles, high phase 3 cycles
	task automatic xfer(input logic [7:0] instr, input logic [15:0] wd, input int nbits,
		input logic fw, output logic [15:0] rd, output logic [3:0] tail,
		output logic [1:0] rel);
		logic [23:0] word;
		word = {instr, wd};
		rd = 16'hxxxx;
		@(negedge clock_in) enable_n_out = 1'b0;
		repeat (4) @(negedge clock_in);
		for (int i = 0; i < nbits; i++)
		begin
			sclk_out = 1'b0;
			host_oe  = (i < 8) || !instr[7];
			host_bit = word[23-i];
			repeat (5) @(negedge clock_in);
			sclk_out = 1'b1;
			if (i >= 8)
				rd[23-i] = fw ? ((read_oe_in && !data_oe_in) ? read_val_in : 1'bx)
					: ((data_oe_in && !read_oe_in) ? data_pin_out : 1'bx);
			repeat (3) @(negedge clock_in);
		end
		sclk_out = 1'b0;
		repeat (6) @(negedge clock_in);
		tail = {data_oe_in, read_oe_in, data_val_in, read_val_in};
		enable_n_out = 1'b1;
		host_oe      = 1'b1;
		repeat (6) @(negedge clock_in);
		rel = {data_oe_in, read_oe_in};
		repeat (4) @(negedge clock_in);
	endtask
endmodule

// >>> serial_config_port_tb.sv
// self-checking bench for the serial configuration port
`timescale 1ns/100ps
module serial_config_port_tb;
	import serial_port_pkg::*;

	logic        clock_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        sclk;
	logic        enable_n;
	logic        data_pin;
	logic        data_val;
	logic        data_oe;
	logic        read_val;
	logic        read_oe;
	logic        four_wire;
	int          err_total  = 0;
	int          n_compared = 0;
	logic [15:0] rd;
	logic [3:0]  tail;
	logic [1:0]  rel;

	serial_config_port dut (
		.clock_in                 (clock_in),
		.reset_in                 (reset_in),
		.serial_clock_in          (sclk),
		.serial_frame_enable_n_in (enable_n),
		.serial_data_in           (data_pin),
		.serial_data_out          (data_val),
		.serial_data_oe_out       (data_oe),
		.serial_read_out          (read_val),
		.serial_read_oe_out       (read_oe),
		.four_wire_select_out     (four_wire)
	);

	serial_host_model host (
		.clock_in     (clock_in),
		.data_val_in  (data_val),
		.data_oe_in   (data_oe),
		.read_val_in  (read_val),
		.read_oe_in   (read_oe),
		.sclk_out     (sclk),
		.enable_n_out (enable_n),
		.data_pin_out (data_pin)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial
	begin
		forever #12.5 clock_in = ~clock_in;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n);
		host.xfer({1'b0, a}, d, n, four_wire, rd, tail, rel);
		check({12'h000, tail}, 16'h0000);
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
		host.xfer({1'b1, a}, 16'h0000, 24, four_wire, rd, tail, rel);
		check(rd, exp);
		check({12'h000, tail}, 16'h000c);
		check({14'h0000, rel}, 16'h0000);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		check({13'h0000, four_wire, data_oe, read_oe}, 16'h0000);
		$display("test reset done");
	endtask

	task automatic t_three_wire;
		wr(7'h05, 16'ha5c3, 24);
		rd_chk(7'h05, 16'ha5c3);
		wr(7'h7f, 16'h8001, 24);
		rd_chk(7'h7f, 16'h8001);
		rd_chk(OPTIONS_ADDR, OPTIONS_RESET);
		$display("test three wire done");
	endtask

	task automatic t_abort;
		wr(7'h05, 16'h1234, 20);
		wr(7'h05, 16'h5678, 9);
		rd_chk(7'h05, 16'ha5c3);
		$display("test abort done");
	endtask

	task automatic t_four_wire;
		wr(OPTIONS_ADDR, 16'h7080, 24);
		check({15'h0000, four_wire}, 16'h0001);
		rd_chk(7'h05, 16'ha5c3);
		rd_chk(OPTIONS_ADDR, 16'h7080);
		wr(OPTIONS_ADDR, OPTIONS_RESET, 24);
		check({15'h0000, four_wire}, 16'h0000);
		rd_chk(7'h7f, 16'h8001);
		$display("test four wire done");
	endtask

	task automatic t_mid_reset;
		wr(OPTIONS_ADDR, 16'h7080, 24);
		check({15'h0000, four_wire}, 16'h0001);
		reset_in = 1'b1;
		repeat (2) @(negedge clock_in);
		reset_in = 1'b0;
		repeat (4) @(negedge clock_in);
		check({13'h0000, four_wire, data_oe, read_oe}, 16'h0000);
		rd_chk(OPTIONS_ADDR, OPTIONS_RESET);
		rd_chk(7'h05, 16'ha5c3);
		$display("test mid reset done");
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (20) @(negedge clock_in);
		reset_in = 1'b0;
		repeat (4) @(negedge clock_in);
		t_reset();
		t_three_wire();
		t_abort();
		t_four_wire();
		t_mid_reset();
		tally_and_finish();
	end

	initial
	begin
		#400000;
		err_total++;
		tally_and_finish();
	end
endmodule
